// ===== tcv_ctrl.sv
// Transfer controller front end: activation, vector fetch, descriptor read, normal-mode move
// Operation
// - software vector address is base plus select bits six..zero shifted left one
// - read start pointer at vector, then descriptor, before any data move
// - vector entry is two bytes, low address bits of on-chip RAM
// - descriptor order mode A, source, mode B, destination, count A, count B
// - chained descriptors sit back to back and are fetched consecutively
// - each hardware source has a fixed vector, IRQ0 at 0420 onward
// - normal mode moves one byte or one word per activation
// - normal mode count spans 1 to 65,536 transfers
// - interrupt to processor possible when count runs out
// - normal mode count comes only from count word A
// - data read from source pointer, written to destination pointer
// - enable bit set routes interrupt to controller, else to processor
// - pending activations served software first, then vector table order
`timescale 1ns/1ps
`default_nettype none
`include "tcv_regs.svh"
module tcv_ctrl #(
   parameter int NSRC = 26,
   parameter int FIFO_W = 16,
   parameter int FIFO_D = `TCV_FIFO_DEPTH
) (
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic [NSRC-1:0]      irq_req,
   input  wire logic [NSRC-1:0]      xfer_enable_bank,
   input  wire logic                 sw_activate,
   input  wire logic [6:0]           sw_vector_select,
   output logic      [NSRC-1:0]      cpu_irq,
   output logic                      bus_req,
   output logic                      bus_we,
   output logic                      bus_word,
   output logic      [23:0]          bus_addr,
   output logic      [15:0]          bus_wdata,
   input  wire logic                 bus_ack,
   input  wire logic [15:0]          bus_rdata,
   output logic                      busy,
   output logic                      done_irq,
   output logic      [4:0]           served_src
);
   import tcv_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Fixed hardware vector offsets, in table priority order
   localparam logic [15:0] VEC_TAB [26] = '{
      16'h0420, 16'h0422, 16'h0424, 16'h0426, 16'h0428, 16'h042A,
      16'h042C, 16'h042E, 16'h0438, 16'h0440, 16'h0442, 16'h0444,
      16'h0446, 16'h0450, 16'h0452, 16'h0458, 16'h045A, 16'h0480,
      16'h0482, 16'h0488, 16'h048A, 16'h04A2, 16'h04A4, 16'h04AA,
      16'h04AC, 16'h04F4};

   tcv_state_t  st_q, st_d;
   logic [23:0] dptr_q, dptr_d;
   logic [2:0]  idx_q, idx_d;
   logic [15:0] desc_q [6];
   logic [15:0] desc_d [6];
   logic [15:0] cnt_q, cnt_d;
   logic [4:0]  src_q, src_d;
   logic        sw_q, sw_d;
   logic        done_q, done_d;
   logic [NSRC-1:0] act;
   logic        hw_hit;
   logic [4:0]  hw_sel;
   logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [15:0] f_out_data;

   ////////////////////////////////////////////////////////////////////
   // Activation routing and priority
   assign act     = irq_req & xfer_enable_bank;
   assign cpu_irq = irq_req & ~xfer_enable_bank;

   always_comb begin
      hw_hit = 1'b0;
      hw_sel = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (act[i]) begin
            hw_hit = 1'b1;
            hw_sel = 5'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data staging FIFO between read and write phases
   tcv_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (bus_rdata),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   assign f_in_valid  = (st_q == TCV_DATRD) && bus_ack;
   assign f_out_ready = (st_q == TCV_DATWR) && bus_ack;

   ////////////////////////////////////////////////////////////////////
   // Bus request decode
   always_comb begin
      bus_req   = 1'b0;
      bus_we    = 1'b0;
      bus_addr  = '0;
      bus_wdata = '0;
      bus_word  = desc_q[`TCV_FLD_MODE_A][`TCV_MODE_SIZE_BIT];
      case (st_q)
         TCV_VREAD: begin
            bus_req  = 1'b1;
            bus_word = 1'b1;
            bus_addr = {8'h00, sw_q ?
               `TCV_SW_VEC_BASE + {8'h00, sw_vector_select, 1'b0}
               : VEC_TAB[src_q]};
         end
         TCV_DREAD: begin
            bus_req  = 1'b1;
            bus_word = 1'b1;
            bus_addr = dptr_q + {20'h0, idx_q, 1'b0};
         end
         TCV_DATRD: begin
            bus_req  = f_in_ready;
            bus_addr = {desc_q[`TCV_FLD_MODE_A][7:0], desc_q[`TCV_FLD_SRC]};
         end
         TCV_DATWR: begin
            bus_req   = f_out_valid;
            bus_we    = 1'b1;
            bus_addr  = {desc_q[`TCV_FLD_MODE_B][7:0], desc_q[`TCV_FLD_DST]};
            bus_wdata = f_out_data;
         end
         TCV_WBACK: begin
            bus_req   = 1'b1;
            bus_we    = 1'b1;
            bus_word  = 1'b1;
            bus_addr  = dptr_q + {20'h0, `TCV_FLD_CNT_A, 1'b0};
            bus_wdata = cnt_q;
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      st_d   = st_q;
      dptr_d = dptr_q;
      idx_d  = idx_q;
      desc_d = desc_q;
      cnt_d  = cnt_q;
      src_d  = src_q;
      sw_d   = sw_q;
      done_d = 1'b0;
      case (st_q)
         TCV_IDLE: begin
            if (sw_activate) begin
               sw_d = 1'b1;
               st_d = TCV_VREAD;
            end else if (hw_hit) begin
               sw_d  = 1'b0;
               src_d = hw_sel;
               st_d  = TCV_VREAD;
            end
         end
         TCV_VREAD: begin
            if (bus_ack) begin
               dptr_d = {`TCV_DESC_HI, bus_rdata};
               idx_d  = '0;
               st_d   = TCV_DREAD;
            end
         end
         TCV_DREAD: begin
            if (bus_ack) begin
               desc_d[idx_q] = bus_rdata;
               idx_d = idx_q + 3'h1;
               if (idx_q == `TCV_DESC_WORDS - 3'h1) begin
                  st_d = TCV_DATRD;
               end
            end
         end
         TCV_DATRD: begin
            if (f_in_valid && f_in_ready) begin
               st_d = TCV_DATWR;
            end
         end
         TCV_DATWR: begin
            if (f_out_ready && f_out_valid) begin
               cnt_d = desc_q[`TCV_FLD_CNT_A] - 16'h0001;
               st_d  = TCV_WBACK;
            end
         end
         TCV_WBACK: begin
            if (bus_ack) begin
               if (desc_q[`TCV_FLD_MODE_B][`TCV_MODE_CHAIN_BIT]) begin
                  dptr_d = dptr_q + 24'h00000C;
                  idx_d  = '0;
                  st_d   = TCV_DREAD;
               end else begin
                  done_d = (cnt_q == 16'h0000)
                     || desc_q[`TCV_FLD_MODE_B][`TCV_MODE_DISEL_BIT];
                  st_d   = TCV_DONE;
               end
            end
         end
         TCV_DONE: st_d = TCV_IDLE;
         default:  st_d = TCV_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q   <= TCV_IDLE;
         dptr_q <= '0;
         idx_q  <= '0;
         desc_q <= '{default: 16'h0000};
         cnt_q  <= '0;
         src_q  <= '0;
         sw_q   <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         dptr_q <= dptr_d;
         idx_q  <= idx_d;
         desc_q <= desc_d;
         cnt_q  <= cnt_d;
         src_q  <= src_d;
         sw_q   <= sw_d;
         done_q <= done_d;
      end
   end

   assign busy       = (st_q != TCV_IDLE);
   assign done_irq   = done_q;
   assign served_src = src_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_vec_taken;
      st_q == TCV_VREAD && bus_ack;
   endsequence

   AST_SW_VEC: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_VREAD && sw_q |-> bus_addr[15:0] == 16'h0400 + {8'h00, sw_vector_select, 1'b0})
      else $error("software vector address wrong");
   AST_VEC_THEN_DESC: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_vec_taken |=> st_q == TCV_DREAD && idx_q == 3'h0)
      else $error("descriptor fetch did not follow vector");
   AST_HI_ONES: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_vec_taken |=> dptr_q == {8'hFF, $past(bus_rdata)})
      else $error("descriptor pointer not extended");
   AST_DESC_ADDR: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_DREAD |-> bus_addr == dptr_q + {20'h0, idx_q, 1'b0})
      else $error("descriptor field address wrong");
   AST_HW_VEC: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_VREAD && !sw_q && src_q == 5'h00 |-> bus_addr[15:0] == 16'h0420)
      else $error("first hardware vector wrong");
   AST_ONE_MOVE: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_DATWR && f_out_ready |=> st_q == TCV_WBACK)
      else $error("more than one unit moved");
   AST_COUNT_A: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_DATWR && f_out_ready |=> cnt_q == $past(desc_q[4]) - 16'h0001)
      else $error("count not taken from count word A");
   AST_ROUTE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cpu_irq & xfer_enable_bank) == '0)
      else $error("enabled interrupt sent to processor");
   AST_HW_TAKEN: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_IDLE && !sw_activate && act != '0 |=> st_q == TCV_VREAD && !sw_q)
      else $error("enabled interrupt did not start a transfer");
   AST_SW_FIRST: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_q == TCV_IDLE && sw_activate |=> st_q == TCV_VREAD && sw_q)
      else $error("software activation not served first");
endmodule
`default_nettype wire

// ===== tcv_ctrl_tb.sv
// Self-checking bench for the transfer controller front end
`timescale 1ns/1ps
`default_nettype none
module tcv_ctrl_tb;
   typedef struct packed {
      logic dn; logic we; logic wd; logic [23:0] a; logic [15:0] d; logic cd;
   } tcv_note_t;
   localparam int SRC [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 25};
   localparam logic [15:0] VEC [10] = '{16'h0420, 16'h0422, 16'h0424, 16'h0426, 16'h0428,
      16'h042A, 16'h042C, 16'h042E, 16'h0438, 16'h04F4};
   logic        sys_clk, resetn, sw_activate, bus_req, bus_we, bus_word, bus_ack, busy, done_irq;
   logic [25:0] irq_req, xfer_enable_bank, cpu_irq;
   logic [6:0]  sw_vector_select;
   logic [23:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, d_ma, d_sa, d_mb, d_da, d_dat;
   logic [4:0]  served_src;
   logic [1:0]  ack_wait;
   integer      seed, failures, n_tests;
   tcv_note_t   exp_q[$];

   tcv_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn), .irq_req(irq_req),
      .xfer_enable_bank(xfer_enable_bank), .sw_activate(sw_activate),
      .sw_vector_select(sw_vector_select), .cpu_irq(cpu_irq), .bus_req(bus_req),
      .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy), .done_irq(done_irq),
      .served_src(served_src));
   tcv_mem_model mem_u (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
      .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .ack_wait(ack_wait), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] rnd();
      return 16'($random(seed));
   endfunction
   task automatic fail(input string m);
      failures++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic note(input logic dn, we, wd, input logic [23:0] a, input logic [15:0] d,
                       input logic cd);
      exp_q.push_back({dn, we, wd, a, d, cd});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Expected access sequence of one descriptor
   task automatic xfer(input logic [15:0] p, ca);
      for (int k = 0; k < 12; k += 2) note(0, 0, 1, {8'hFF, p + 16'(k)}, 16'h0, 0);
      note(0, 0, d_ma[8], {d_ma[7:0], d_sa}, 16'h0, 0);
      note(0, 1, d_ma[8], {d_mb[7:0], d_da}, d_dat, d_ma[8]);
      note(0, 1, 1, {8'hFF, p + 16'h8}, ca - 16'h1, 1);
      if (ca == 16'h1 || d_mb[5]) note(1, 0, 0, 24'h0, 16'h0, 0);
   endtask
   task automatic desc(input logic [15:0] p, ma, mb, ca);
      logic [15:0] w [6];
      d_ma = ma;
      d_mb = mb;
      d_sa = rnd() & 16'hFFFE;
      d_da = rnd() & 16'hFFFE;
      d_dat = rnd();
      w = '{ma, d_sa, mb, d_da, ca, rnd()};
      for (int k = 0; k < 6; k++) mem_u.put({8'hFF, p + 16'(2 * k)}, w[k]);
      mem_u.put({ma[7:0], d_sa}, d_dat);
      xfer(p, ca);
   endtask
   // Pointers stay aligned to four inside on-chip RAM
   task automatic vput(input logic [15:0] v, p);
      mem_u.put({8'h00, v}, p);
      note(0, 0, 1, {8'h00, v}, 16'h0, 0);
   endtask
   task automatic wait_done();
      int k;
      for (k = 0; k < 400 && done_irq !== 1'b1; k++) @(posedge sys_clk);
      if (k == 400) fail("no completion");
      #1;
   endtask
   task automatic cmp_val(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask
   task automatic cmp_acc();
      tcv_note_t n;
      n_tests++;
      if (exp_q.size() == 0) begin
         fail($sformatf("stray access %h", bus_addr));
         return;
      end
      n = exp_q.pop_front();
      if (n.dn || bus_we !== n.we || bus_word !== n.wd || bus_addr !== n.a ||
          (n.cd && bus_wdata !== n.d))
         fail($sformatf("access %h we %b exp %h", bus_addr, bus_we, n.a));
   endtask
   task automatic cmp_done();
      n_tests++;
      if (exp_q.size() == 0 || !exp_q[0].dn) fail("stray completion");
      else void'(exp_q.pop_front());
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (resetn === 1'b1 && bus_req === 1'b1 && bus_ack === 1'b1) cmp_acc();
      if (resetn === 1'b1 && done_irq === 1'b1) cmp_done();
   end

   // Roughly twenty to forty times the expected run
   initial begin
      #200000;
      failures++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] p;
      logic [25:0] b;
      seed = 32'h9218;
      failures = 0;
      n_tests = 0;
      resetn = 1'b0;
      sw_activate = 1'b0;
      sw_vector_select = 7'h00;
      irq_req = 26'h0;
      xfer_enable_bank = 26'h0;
      ack_wait = 2'h0;
      repeat (6) @(posedge sys_clk);
      #1 resetn = 1'b1;
      // Software activation, top select value
      vput(16'h04FE, 16'hEFB4);
      desc(16'hEFB4, 16'h0120, 16'h0010, 16'h0001);
      sw_vector_select = 7'h7F;
      sw_activate = 1'b1;
      wait_done();
      sw_activate = 1'b0;
      $display("test sw_vector finished");
      // Hardware sources, byte and word, random bus waits
      foreach (SRC[j]) begin
         p = 16'hEC00 + 16'(j * 16);
         ack_wait = 2'($random(seed));
         vput(VEC[j], p);
         desc(p, {7'h0, j[0], 8'h20}, 16'h0010, 16'h0001);
         b = 26'h1 << SRC[j];
         xfer_enable_bank = b;
         irq_req = b | (26'($random(seed)) & ~b);
         wait_done();
         cmp_val(32'(cpu_irq), 32'(irq_req & ~b), "cpu_irq");
         cmp_val(32'(served_src), 32'(SRC[j]), "served_src");
         irq_req = 26'h0;
         xfer_enable_bank = 26'h0;
      end
      $display("test hw_sources finished");
      // Held request walks a count of three to zero
      vput(VEC[2], 16'hED00);
      desc(16'hED00, 16'h0120, 16'h0010, 16'h0003);
      for (int k = 2; k > 0; k--) begin
         vput(VEC[2], 16'hED00);
         xfer(16'hED00, 16'(k));
      end
      // Source zero enabled but quiet, so only source two runs
      xfer_enable_bank = 26'h5;
      irq_req = 26'h4;
      wait_done();
      // Count zero stands for 65536; disable bit still completes
      vput(VEC[0], 16'hED20);
      desc(16'hED20, 16'h0120, 16'h0030, 16'h0000);
      irq_req = 26'h1;
      wait_done();
      irq_req = 26'h0;
      xfer_enable_bank = 26'h0;
      $display("test counts finished");
      // Two chained descriptors from one activation
      vput(16'h0400, 16'hED40);
      desc(16'hED40, 16'h0120, 16'h0090, 16'h0005);
      desc(16'hED4C, 16'h0120, 16'h0010, 16'h0001);
      sw_vector_select = 7'h00;
      sw_activate = 1'b1;
      wait_done();
      sw_activate = 1'b0;
      $display("test chain finished");
      // Software, IRQ3 and converter source at once
      vput(16'h040A, 16'hED60);
      desc(16'hED60, 16'h0120, 16'h0010, 16'h0001);
      vput(VEC[3], 16'hED70);
      desc(16'hED70, 16'h0020, 16'h0010, 16'h0001);
      vput(VEC[8], 16'hED80);
      desc(16'hED80, 16'h0120, 16'h0010, 16'h0001);
      sw_vector_select = 7'h05;
      xfer_enable_bank = 26'h108;
      irq_req = 26'h108;
      sw_activate = 1'b1;
      wait_done();
      sw_activate = 1'b0;
      wait_done();
      irq_req = 26'h100;
      wait_done();
      cmp_val(32'(served_src), 32'h8, "served_src");
      irq_req = 26'h0;
      xfer_enable_bank = 26'h0;
      repeat (4) @(posedge sys_clk);
      cmp_val(32'(exp_q.size()), 32'h0, "notes left");
      $display("test priority finished");
      final_report();
   end
endmodule
`default_nettype wire

// ===== tcv_fifo.sv
// Parameterised valid/ready FIFO for transfer data
`timescale 1ns/1ps
`default_nettype none
module tcv_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== tcv_mem_model.sv
// Behavioural on-chip RAM answering the controller's internal bus
`timescale 1ns/1ps
`default_nettype none
module tcv_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        bus_req,
   input  wire logic        bus_we,
   input  wire logic        bus_word,
   input  wire logic [23:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic [1:0]  ack_wait,
   output logic             bus_ack,
   output logic      [15:0] bus_rdata
);
   logic [15:0] mem [int];
   logic [1:0]  cnt_q;

   // Two-byte words, descriptor fields in ascending order
   task automatic put(input logic [23:0] a, input logic [15:0] d);
      mem[int'(a[23:1])] = d;
   endtask

   // Ack after ack_wait cycles; read data scrambled outside acks
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bus_ack <= 1'b0;
         bus_rdata <= 16'hA5A5;
         cnt_q <= 2'h0;
      end else if (bus_ack) begin
         bus_ack <= 1'b0;
         bus_rdata <= ~bus_rdata;
         cnt_q <= 2'h0;
         if (bus_we) mem[int'(bus_addr[23:1])] = bus_word ? bus_wdata : {2{bus_wdata[7:0]}};
      end else if (bus_req && cnt_q >= ack_wait) begin
         bus_ack <= 1'b1;
         bus_rdata <= mem.exists(int'(bus_addr[23:1])) ? mem[int'(bus_addr[23:1])] : ~bus_rdata;
      end else if (bus_req) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ===== tcv_pkg.sv
// Types for the transfer controller vector fetch block
package tcv_pkg;
   typedef enum logic [3:0] {
      TCV_IDLE   = 4'b0000,
      TCV_VREAD  = 4'b0001,
      TCV_DREAD  = 4'b0010,
      TCV_DATRD  = 4'b0011,
      TCV_DATWR  = 4'b0100,
      TCV_WBACK  = 4'b0101,
      TCV_DONE   = 4'b0110
   } tcv_state_t;
endpackage

// ===== tcv_regs.svh
// Constants for the transfer controller vector fetch block
`ifndef TCV_REGS_SVH
`define TCV_REGS_SVH

`define TCV_SW_VEC_BASE    16'h0400
`define TCV_HW_VEC_BASE    16'h0420
`define TCV_LAST_VEC       16'h04F4
`define TCV_DESC_HI        8'hFF
`define TCV_DESC_WORDS     3'h6
`define TCV_FLD_MODE_A     3'h0
`define TCV_FLD_SRC        3'h1
`define TCV_FLD_MODE_B     3'h2
`define TCV_FLD_DST        3'h3
`define TCV_FLD_CNT_A      3'h4
`define TCV_FLD_CNT_B      3'h5
`define TCV_MODE_SIZE_BIT  8
`define TCV_MODE_CHAIN_BIT 7
`define TCV_MODE_DISEL_BIT 5
`define TCV_FIFO_DEPTH     16

`endif
